// [logic/i2cr_regs.sv]
// i2c tx dma request control, baud rate count and interrupt mask registers
//
// Operation
// (RULE_01) burst length field bits 10:8 counts only while burst select is one.
// (RULE_02) burst length below remaining transfer length gives single requests only.
// (RULE_03) burst select zero: single requests, one byte each into tx fifo.
// (RULE_04) burst select one: burst requests moving the programmed burst length.
// (RULE_05) burst mode still finishes a transfer with single requests where needed.
// (RULE_06) 16-bit baud rate count, reset 8, sets master standard/fast bus rate.
// (RULE_07) mask bit 0 gates the tx fifo empty interrupt.
// (RULE_08) mask bit 1 gates the tx fifo nearly empty interrupt.
// (RULE_09) mask bit 2 gates the tx fifo full interrupt.
// (RULE_10) mask bit 3 gates the tx fifo overrun interrupt.
// (RULE_11) mask bit 4 gates the rx fifo empty interrupt.
// (RULE_12) mask bit 5 gates the rx fifo nearly full interrupt.
// (RULE_13) mask bit 6 gates the rx fifo full interrupt.
// (RULE_14) mask bit 16 gates the master read-from-slave request interrupt.
// (RULE_15) mask bit 17 gates the slave transmit data empty during read interrupt.
// (RULE_16) mask bit 18 gates the master write-to-slave request interrupt.
// (RULE_17) mask bit 19 gates the master transaction done interrupt.
// (RULE_18) mask bit 20 gates the slave transaction done interrupt.
// (RULE_19) mask bit 24 gates the master arbitration lost interrupt.
// (RULE_20) mask bit 25 gates the bus error interrupt.
// (RULE_21) mask bit 28 gates the master done without stop interrupt.
// (RULE_22) tx nearly empty flag high while tx count at or below threshold.
// (RULE_23) interrupt output high while any flag and its mask are both one.
// (RULE_24) reserved bits read zero and writes to them do nothing.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "i2cr_defs.svh"

module i2cr_regs #(
   parameter int CNT_W = 16,
   parameter int LVL_W = 11,
   parameter int THR_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire i2cr_pkg::i2cr_bus_req_t bus_i,
   output logic [31:0] rdata_o,
   input wire i2cr_pkg::i2cr_flags_t raw_flags_i,
   input wire logic [LVL_W-1:0] tx_level_i,
   input wire logic [THR_W-1:0] tx_threshold_i,
   input wire logic tx_dma_en_i,
   input wire logic [CNT_W-1:0] tx_remaining_i,
   input wire logic [LVL_W-1:0] tx_space_i,
   input wire logic dma_done_i,
   output i2cr_pkg::i2cr_dma_req_t dma_req_o,
   output logic [2:0] dma_beats_log2_o,
   output logic [15:0] rate_divider_count_o,
   output logic tx_queue_low_flag_o,
   output logic irq_o
);
   import i2cr_pkg::*;

   // register state
   logic [2:0] tx_burst_length_q;
   logic tx_burst_sel_q;
   logic [15:0] rate_q;
   i2cr_gates_t mask_q;
   logic [31:0] rdata_q;
   logic tx_low_q;
   logic irq_q;
   i2cr_dma_state_t state_q;
   i2cr_dma_state_t state_d;
   i2cr_dma_req_t req_q;
   i2cr_dma_req_t req_d;
   logic [2:0] beats_log2_q;
   logic [2:0] beats_log2_d;

   // address decode
   wire sel_dma = (bus_i.addr == `I2CR_OFF_TX_DMA_CTRL);
   wire sel_rate = (bus_i.addr == `I2CR_OFF_RATE_CNT);
   wire sel_mask = (bus_i.addr == `I2CR_OFF_IRQ_MASK);
   wire wr_dma = en_i & bus_i.wr & sel_dma;
   wire wr_rate = en_i & bus_i.wr & sel_rate;
   wire wr_mask = en_i & bus_i.wr & sel_mask;

   // read views, reserved positions forced to zero
   wire [31:0] dma_view = {20'h0_0000, tx_burst_sel_q, tx_burst_length_q, 8'h00}; // RULE_24
   wire [31:0] rate_view = {16'h0000, rate_q}; // RULE_24
   wire [31:0] mask_view = mask_q & `I2CR_MASK_WRITABLE; // RULE_24
   wire [31:0] read_mux = sel_dma ? dma_view :
                          sel_rate ? rate_view :
                          sel_mask ? mask_view : `I2CR_ZERO32;
   wire [31:0] rdata_d = bus_i.rd ? read_mux : `I2CR_ZERO32;

   // tx dma control register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_burst_length_q <= 3'h0;
         tx_burst_sel_q <= 1'b0;
      end else if (wr_dma) begin
         tx_burst_length_q <= bus_i.wdata[`I2CR_BURST_LEN_MSB:`I2CR_BURST_LEN_LSB];
         tx_burst_sel_q <= bus_i.wdata[`I2CR_BURST_SEL_BIT];
      end
   end

   // baud rate count, reset value 8
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rate_q <= `I2CR_RATE_RESET; // RULE_06
      end else if (wr_rate) begin
         rate_q <= bus_i.wdata[`I2CR_RATE_MSB:0]; // RULE_06
      end
   end

   // interrupt mask, only defined gates are stored
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= `I2CR_MASK_RESET;
      end else if (wr_mask) begin
         mask_q <= bus_i.wdata & `I2CR_MASK_WRITABLE; // RULE_24
      end
   end

   // read data stands from the strobe until the next strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= `I2CR_ZERO32;
      end else if (en_i) begin
         rdata_q <= rdata_d;
      end
   end

   // tx nearly empty flag from the fifo level and threshold
   wire tx_low_d = ({1'b0, tx_level_i} <= {{(LVL_W + 1 - THR_W){1'b0}}, tx_threshold_i}); // RULE_22

   // flags with the tx nearly empty flag produced here
   i2cr_flags_t flags;
   always_comb begin
      flags = raw_flags_i;
      flags.tx_queue_low_flag = tx_low_q; // RULE_22
   end

   // per-source gating
   i2cr_flags_t gated;
   always_comb begin
      gated = '0;
      gated.tx_queue_empty_flag = flags.tx_queue_empty_flag & mask_q.tx_empty_gate; // RULE_07
      gated.tx_queue_low_flag = flags.tx_queue_low_flag & mask_q.tx_low_level_gate; // RULE_08
      gated.tx_queue_full_flag = flags.tx_queue_full_flag & mask_q.tx_full_gate; // RULE_09
      gated.tx_queue_overflow_flag =
         flags.tx_queue_overflow_flag & mask_q.tx_overflow_gate; // RULE_10
      gated.rx_queue_empty_flag = flags.rx_queue_empty_flag & mask_q.rx_empty_gate; // RULE_11
      gated.rx_queue_high_flag = flags.rx_queue_high_flag & mask_q.rx_high_level_gate; // RULE_12
      gated.rx_queue_full_flag = flags.rx_queue_full_flag & mask_q.rx_full_gate; // RULE_13
      gated.slave_read_request_flag =
         flags.slave_read_request_flag & mask_q.slave_read_request_gate; // RULE_14
      gated.slave_read_underrun_flag =
         flags.slave_read_underrun_flag & mask_q.slave_read_underrun_gate; // RULE_15
      gated.slave_write_request_flag =
         flags.slave_write_request_flag & mask_q.slave_write_request_gate; // RULE_16
      gated.master_done_flag = flags.master_done_flag & mask_q.master_done_gate; // RULE_17
      gated.slave_done_flag = flags.slave_done_flag & mask_q.slave_done_gate; // RULE_18
      gated.arbitration_lost_flag =
         flags.arbitration_lost_flag & mask_q.arbitration_lost_gate; // RULE_19
      gated.bus_fault_flag = flags.bus_fault_flag & mask_q.bus_fault_gate; // RULE_20
      gated.master_done_nostop_flag =
         flags.master_done_nostop_flag & mask_q.master_done_nostop_gate; // RULE_21
   end

   wire irq_d = |gated; // RULE_23

   // registered flag and interrupt outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_low_q <= 1'b1;
         irq_q <= 1'b0;
      end else if (en_i) begin
         tx_low_q <= tx_low_d; // RULE_22
         irq_q <= irq_d; // RULE_23
      end
   end

   // burst size in bytes is a power of two of the field
   wire [7:0] beats = 8'h01 << tx_burst_length_q; // RULE_01
   wire [CNT_W-1:0] beats_w = CNT_W'(beats);
   wire burst_smaller = beats_w < tx_remaining_i; // RULE_02
   wire burst_fits = tx_burst_sel_q & ~burst_smaller & (beats_w == tx_remaining_i); // RULE_04
   wire burst_room = {{(CNT_W - LVL_W){1'b0}}, tx_space_i} >= beats_w;
   wire any_left = (tx_remaining_i != '0) & (tx_space_i != '0);

   // request sequencer: one request raised and held until the dma controller finishes it or tx dma is disabled
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      beats_log2_d = beats_log2_q;
      case (state_q)
         I2CR_DMA_IDLE: begin
            if (tx_dma_en_i & burst_fits & burst_room) begin
               state_d = I2CR_DMA_BURST; // RULE_04
               req_d.burst_req = 1'b1;
               beats_log2_d = tx_burst_length_q; // RULE_01
            end else if (tx_dma_en_i & any_left) begin
               state_d = I2CR_DMA_SINGLE; // RULE_03 RULE_05
               req_d.single_req = 1'b1;
               beats_log2_d = 3'h0;
            end
         end
         I2CR_DMA_SINGLE, I2CR_DMA_BURST: begin
            if (dma_done_i | ~tx_dma_en_i) begin
               state_d = I2CR_DMA_IDLE;
               req_d = '0;
            end
         end
         default: begin
            state_d = I2CR_DMA_IDLE;
            req_d = '0;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= I2CR_DMA_IDLE;
         req_q <= '0;
         beats_log2_q <= 3'h0;
      end else if (en_i) begin
         state_q <= state_d;
         req_q <= req_d;
         beats_log2_q <= beats_log2_d;
      end
   end

   assign rdata_o = rdata_q;
   assign dma_req_o = req_q;
   assign dma_beats_log2_o = beats_log2_q;
   assign rate_divider_count_o = rate_q; // RULE_06
   assign tx_queue_low_flag_o = tx_low_q;
   assign irq_o = irq_q;

endmodule : i2cr_regs

// [logic/i2cr_defs.svh]
// register offsets, field positions and reset values of the i2c rate, dma and mask registers
`ifndef I2CR_DEFS_SVH
`define I2CR_DEFS_SVH

`define I2CR_ADDR_W 8
`define I2CR_OFF_TX_DMA_CTRL 8'h24
`define I2CR_OFF_RATE_CNT 8'h28
`define I2CR_OFF_IRQ_MASK 8'h2C

`define I2CR_BURST_LEN_LSB 8
`define I2CR_BURST_LEN_MSB 10
`define I2CR_BURST_SEL_BIT 11
`define I2CR_RATE_MSB 15

`define I2CR_DMA_RESET 32'h0000_0000
`define I2CR_RATE_RESET 16'h0008
`define I2CR_MASK_RESET 32'h0000_0000
`define I2CR_MASK_WRITABLE 32'h131F_007F
`define I2CR_ZERO32 32'h0000_0000

`endif

// [logic/i2cr_pkg.sv]
// types shared by the i2c rate, dma and mask register block
package i2cr_pkg;

   // raw interrupt flags, laid out as in the mask register
   typedef struct packed {
      logic [2:0] rsv_31_29;
      logic master_done_nostop_flag;
      logic [1:0] rsv_27_26;
      logic bus_fault_flag;
      logic arbitration_lost_flag;
      logic [2:0] rsv_23_21;
      logic slave_done_flag;
      logic master_done_flag;
      logic slave_write_request_flag;
      logic slave_read_underrun_flag;
      logic slave_read_request_flag;
      logic [8:0] rsv_15_7;
      logic rx_queue_full_flag;
      logic rx_queue_high_flag;
      logic rx_queue_empty_flag;
      logic tx_queue_overflow_flag;
      logic tx_queue_full_flag;
      logic tx_queue_low_flag;
      logic tx_queue_empty_flag;
   } i2cr_flags_t;

   // interrupt gates, same bit layout
   typedef struct packed {
      logic [2:0] rsv_31_29;
      logic master_done_nostop_gate;
      logic [1:0] rsv_27_26;
      logic bus_fault_gate;
      logic arbitration_lost_gate;
      logic [2:0] rsv_23_21;
      logic slave_done_gate;
      logic master_done_gate;
      logic slave_write_request_gate;
      logic slave_read_underrun_gate;
      logic slave_read_request_gate;
      logic [8:0] rsv_15_7;
      logic rx_full_gate;
      logic rx_high_level_gate;
      logic rx_empty_gate;
      logic tx_overflow_gate;
      logic tx_full_gate;
      logic tx_low_level_gate;
      logic tx_empty_gate;
   } i2cr_gates_t;

   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } i2cr_bus_req_t;

   // dma request pair toward the dma controller
   typedef struct packed {
      logic single_req;
      logic burst_req;
   } i2cr_dma_req_t;

   // tx dma request sequencer, three states in a two-bit code (idle to burst flips both bits)
   typedef enum logic [1:0] {
      I2CR_DMA_IDLE = 2'h0,
      I2CR_DMA_SINGLE = 2'h1,
      I2CR_DMA_BURST = 2'h3
   } i2cr_dma_state_t;

endpackage : i2cr_pkg

// [test/i2cr_regs_assertions.sv]
// assertion checker of the i2c rate, dma and mask register block
`timescale 1ns/100ps
module i2cr_regs_chk #(
   parameter int CNT_W = 16, parameter int LVL_W = 11, parameter int THR_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire i2cr_pkg::i2cr_bus_req_t bus_i,
   input wire logic [31:0] rdata_o,
   input wire i2cr_pkg::i2cr_flags_t raw_flags_i,
   input wire logic [LVL_W-1:0] tx_level_i,
   input wire logic [THR_W-1:0] tx_threshold_i,
   input wire logic [CNT_W-1:0] tx_remaining_i,
   input wire logic dma_done_i,
   input wire i2cr_pkg::i2cr_dma_req_t dma_req_o,
   input wire logic [2:0] dma_beats_log2_o,
   input wire logic [15:0] rate_divider_count_o,
   input wire logic tx_queue_low_flag_o,
   input wire logic irq_o
);
   import i2cr_pkg::*;
   logic [31:0] dma_q, mask_q;
   // read value and masked flags as the registers stand now
   wire [31:0] rd_exp = bus_i.addr == 8'h24 ? dma_q : bus_i.addr == 8'h2C ? mask_q :
      bus_i.addr == 8'h28 ? {16'h0000, rate_divider_count_o} : 32'h0000_0000;
   wire hit = |(raw_flags_i & mask_q & 32'hFFFF_FFFD) | tx_queue_low_flag_o & mask_q[1];
   // shadow copies of the writable dma and mask fields
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dma_q <= 32'h0000_0000;
         mask_q <= 32'h0000_0000;
      end else if (en_i && bus_i.wr) begin
         if (bus_i.addr == 8'h24) dma_q <= bus_i.wdata & 32'h0000_0F00;
         if (bus_i.addr == 8'h2C) mask_q <= bus_i.wdata & 32'h131F_007F;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req_done; en_i && dma_req_o != 2'b00 && dma_done_i; endsequence
   sequence s_req_gone; dma_req_o == 2'b00; endsequence
   irq_gate_a: assert property (en_i |=> irq_o == $past(hit))
      else $error("irq not equal to masked flags");
   read_data_a: assert property (en_i && bus_i.rd |=> rdata_o == $past(rd_exp))
      else $error("read data wrong");
   rate_write_a: assert property (en_i && bus_i.wr && bus_i.addr == 8'h28
      |=> rate_divider_count_o == $past(bus_i.wdata[15:0])) else $error("rate not written");
   low_flag_a: assert property (en_i |=> tx_queue_low_flag_o ==
      ($past(tx_level_i) <= {1'b0, $past(tx_threshold_i)})) else $error("tx low flag wrong");
   burst_select_a: assert property (dma_req_o.burst_req |-> dma_q[11])
      else $error("burst request without burst select");
   single_size_a: assert property (dma_req_o.single_req |->
      !dma_req_o.burst_req && dma_beats_log2_o == 3'h0) else $error("single request size");
   burst_size_a: assert property ($rose(dma_req_o.burst_req) |->
      dma_beats_log2_o == dma_q[10:8] && $past(tx_remaining_i) == 16'h0001 << dma_q[10:8])
      else $error("burst size wrong");
   req_drop_a: assert property (s_req_done |=> s_req_gone)
      else $error("request held after done");
endmodule : i2cr_regs_chk

bind i2cr_regs i2cr_regs_chk #(.CNT_W(CNT_W), .LVL_W(LVL_W), .THR_W(THR_W)) i2cr_regs_chk_i (
   .clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .raw_flags_i(raw_flags_i), .tx_level_i(tx_level_i), .tx_threshold_i(tx_threshold_i),
   .tx_remaining_i(tx_remaining_i), .dma_done_i(dma_done_i), .dma_req_o(dma_req_o),
   .dma_beats_log2_o(dma_beats_log2_o), .rate_divider_count_o(rate_divider_count_o),
   .tx_queue_low_flag_o(tx_queue_low_flag_o), .irq_o(irq_o));

// [test/i2cr_dma_model.sv]
// dma controller model answering tx dma requests after a set wait
`timescale 1ns/100ps
module i2cr_dma_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire i2cr_pkg::i2cr_dma_req_t req_i,
   input wire logic [2:0] beats_i,
   input wire logic [2:0] wait_i,
   input wire logic load_i,
   input wire logic [15:0] load_val_i,
   output logic done_o,
   output logic [15:0] remaining_o
);
   import i2cr_pkg::*;
   logic [2:0] cnt_q;
   wire fire = req_i != 2'b00 && !done_o && cnt_q == wait_i;
   // wait, answer once with a one-cycle done, take the moved bytes off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 3'h0;
         done_o <= 1'b0;
         remaining_o <= 16'h0000;
      end else if (load_i) begin
         remaining_o <= load_val_i;
      end else begin
         done_o <= fire;
         cnt_q <= (req_i == 2'b00 || done_o || fire) ? 3'h0 : cnt_q + 3'h1;
         if (fire) remaining_o <= remaining_o - (req_i.burst_req ? 16'h1 << beats_i : 16'h1);
      end
   end
endmodule : i2cr_dma_model

// [test/i2cr_regs_tb.sv]
// self-checking bench of the i2c rate, dma and mask register block
`timescale 1ns/100ps
module i2cr_regs_tb;
   import i2cr_pkg::*;
   logic clk, rst = 1'b1, load = 1'b0, en = 1'b1, done, low, irq;
   logic [31:0] keep;
   i2cr_bus_req_t bus = '0;
   i2cr_dma_req_t req, req_p = '0;
   logic [31:0] rdata, flags = '0;
   logic [31:0] m[4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0008, 32'h0000_0000};
   logic [31:0] wm[4] = '{32'h0000_0000, 32'h0000_0F00, 32'h0000_FFFF, 32'h131F_007F};
   logic [15:0] rate, rem, ld = '0;
   logic [10:0] lvl = '0;
   logic [7:0] a;
   logic [2:0] beats, lat = '0;
   logic [1:0] ex;
   int fails = 0, checks_done = 0, n_req = 0, n_exp, r, cnt;
   int sel_t[4] = '{0, 1, 1, 1};
   int fld_t[4] = '{7, 2, 3, 0};
   int len_t[4] = '{3, 5, 4, 1};
   i2cr_regs i2cr_regs_i (.clk_i(clk), .rst_i(rst), .en_i(en), .bus_i(bus), .rdata_o(rdata),
      .raw_flags_i(flags), .tx_level_i(lvl), .tx_threshold_i(10'h010), .tx_dma_en_i(1'b1),
      .tx_remaining_i(rem), .tx_space_i(11'h400), .dma_done_i(done), .dma_req_o(req),
      .dma_beats_log2_o(beats), .rate_divider_count_o(rate), .tx_queue_low_flag_o(low),
      .irq_o(irq));
   i2cr_dma_model i2cr_dma_model_i (.clk_i(clk), .rst_i(rst), .req_i(req), .beats_i(beats),
      .wait_i(lat), .load_i(load), .load_val_i(ld), .done_o(done), .remaining_o(rem));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      bus <= '{ad, d, 1'b1, 1'b0};
      m[ad[3:2]] = d & wm[ad[3:2]];
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      @(posedge clk);
      bus <= '{ad, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 cmp("read data", m[ad[3:2]], rdata);
   endtask : rd
   task automatic conclude();
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // bench model of the kind of each new dma request
   always @(posedge clk) begin
      if (req != 2'b00 && req_p == 2'b00) begin
         n_req++;
         ex = m[1][11] && 32'h1 << m[1][10:8] == rem ? 2'b01 : 2'b10;
         cmp("dma request", ex, req);
      end
      req_p = req;
   end
   // main sequence: registers, interrupt gates, dma requests
   initial begin
      void'($urandom(15));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 1; k < 5; k++) rd(8'h20 + 8'(4 * k));
      for (int k = 0; k < 16; k++) begin
         a = 8'h24 + 8'(4 * (k % 4));
         wr(a, $urandom);
         rd(a);
         cmp("rate count", m[2], {16'h0000, rate});
      end
      // a write with the clock enable low must be lost
      keep = m[2];
      en <= 1'b0;
      wr(8'h28, $urandom);
      m[2] = keep;
      en <= 1'b1;
      rd(8'h28);
      cmp("frozen rate count", m[2], {16'h0000, rate});
      for (int i = 0; i < 29; i++) begin
         if (wm[3][i]) begin
            wr(8'h2C, 32'h1 << i);
            flags <= 32'h1 << i & 32'hFFFF_FFFD;
            lvl <= i == 1 ? 11'h010 : 11'h011;
            repeat (3) @(posedge clk);
            #1 cmp("irq set", 1, irq);
            cmp("low flag", i == 1, low);
            @(posedge clk);
            flags <= ~(32'h1 << i);
            lvl <= 11'h011;
            repeat (3) @(posedge clk);
            #1 cmp("irq clear", 0, irq);
         end
      end
      foreach (len_t[j]) begin
         wr(8'h24, {20'h0_0000, sel_t[j][0], 3'(fld_t[j]), 8'hFF});
         lat <= 3'($urandom_range(5));
         ld <= 16'(len_t[j]);
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         n_req = 0;
         r = len_t[j];
         n_exp = 0;
         while (r > 0) begin
            r = sel_t[j] != 0 && 1 << fld_t[j] == r ? 0 : r - 1;
            n_exp++;
         end
         cnt = 0;
         repeat (2) @(posedge clk);
         while ((rem !== 16'h0000 || req !== 2'b00) && cnt < 999) begin
            @(posedge clk);
            cnt++;
         end
         if (cnt >= 999) fails++;
         cmp("request count", n_exp, n_req);
      end
      conclude();
   end
   // cut a hung run short
   initial begin
      #100000;
      fails++;
      conclude();
   end
endmodule : i2cr_regs_tb
